// *** rtl/srcic_config_regs.v ***
// Purpose: sync, reference and clock-input configuration registers
// Assumes: host writes/reads bytes through the serial register port decode
// Notes:   analog blocks and sync distribution sit outside this module
//          pin paths lag by four edges through the synchroniser, so a
//          level on either pin is ignored until it has settled
//          the software sync pulse lasts one clock; a host that wants
//          a second command must toggle the trigger bit again
//          unmapped offsets are ignored on write and read back as zero
//
// Overview of operation
// - Bit 7 of the first register makes a high shared pin mean power-down (0) or sync (1).
// - While bit 5 is set, each change of the software sync bit issues a sync command; the bit never clears itself.
// - Bit 5 of the first register moves sync from the shared pin to the register trigger.
// - Bit 3 of the first register picks the reference from the buffer pin (0) or bits 2:1 (1).
// - Reference field codes are 00 internal, 01 buffered external 1.2 V, 10 external, 11 unused.
// - Bit 0 of the first register selects single-ended clock only while reference control is 1.
// - Bit 5 of the second register makes channel A input single-ended.
// - Bit 4 of the second register makes channel B input single-ended.
// - Bit 2 of the second register, fastest variant only, powers down the delay loop.
// - Bit 0 of the second register enables auto-zero, reset 1 on slow and 0 on fast variants.
`timescale 1ns/1ps
`default_nettype none
`include "srcic_defines.vh"

module srcic_config_regs
#(
  parameter FAST_VARIANT = 0
)
(
  // clock and reset
  input  wire       core_clk,
  input  wire       nrst,
  // register port
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  // device pins
  input  wire       shared_sync_powerdown_pin,
  input  wire       reference_buffer_pin,
  // steering outputs
  output reg        global_powerdown,
  output reg        sync_command,
  output reg  [1:0] reference_select,
  output reg        single_ended_clock_select,
  output reg        chan_a_single_ended,
  output reg        chan_b_single_ended,
  output reg        delay_loop_powerdown,
  output reg        autozero_enable
);

  // variant-dependent reset value and write mask of the second register
  localparam [7:0] INPUT_RESET = FAST_VARIANT ? `SRCIC_RST_INPUT_FAST
                                              : `SRCIC_RST_INPUT_SLOW;
  localparam [7:0] INPUT_MASK  = FAST_VARIANT ? `SRCIC_MASK_INPUT_MODE
                                              : `SRCIC_MASK_INPUT_FAST;

  reg  [7:0] sync_reference_clock_control;
  reg  [7:0] input_mode_dll_autozero;
  reg        sw_sync_prev;
  reg        buf_pin_prev;
  wire       pin_high;
  wire       buf_pin_level;
  wire       pin_role_sync;
  wire       sw_sync_en;
  wire       ref_src_control;
  wire       wr_sync_ref;
  wire       wr_input_mode;
  wire       sw_sync_bit;
  wire       sw_sync_edge;
  wire [1:0] ref_field;
  wire [1:0] ref_from_pin;
  reg  [7:0] next_rdata;

  // pins come from outside the clock domain
  srcic_pin_sync u_sync_pin
  (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .pin_in    (shared_sync_powerdown_pin),
    .pin_level (pin_high)
  );

  srcic_pin_sync u_ref_buffer_pin
  (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .pin_in    (reference_buffer_pin),
    .pin_level (buf_pin_level)
  );

  // control bits of the first register
  assign pin_role_sync   = sync_reference_clock_control[`SRCIC_BIT_PIN_ROLE];
  assign sw_sync_en      = sync_reference_clock_control[`SRCIC_BIT_SW_SYNC_EN];
  assign ref_src_control = sync_reference_clock_control[`SRCIC_BIT_REF_SRC_CTRL];

  // write decode per register; unmapped offsets match neither
  assign wr_sync_ref   = reg_wr & (reg_addr == `SRCIC_OFS_SYNC_REF_CLK);
  assign wr_input_mode = reg_wr & (reg_addr == `SRCIC_OFS_INPUT_MODE);

  // trigger edge; either direction counts, so the host never has to
  // clear the bit before the next command
  assign sw_sync_bit  = sync_reference_clock_control[`SRCIC_BIT_SW_SYNC];
  assign sw_sync_edge = sw_sync_bit ^ sw_sync_prev;

  // reference field and the fallback choice taken from the buffer pin
  assign ref_field    = sync_reference_clock_control[`SRCIC_BIT_REF_SEL_HI:
                                                     `SRCIC_BIT_REF_SEL_LO];
  assign ref_from_pin = buf_pin_prev ? `SRCIC_REF_EXT_BUFFERED : `SRCIC_REF_INTERNAL;

  // register writes; reserved bits are stored as zero whatever the host sends
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync_reference_clock_control <= `SRCIC_RST_SYNC_REF_CLK;
      input_mode_dll_autozero      <= INPUT_RESET;
    end
    else if (reg_wr)
    begin
      if (wr_sync_ref)
        sync_reference_clock_control <= reg_wdata & `SRCIC_MASK_SYNC_REF_CLK;
      // delay loop bit only on fast variant
      if (wr_input_mode)
        input_mode_dll_autozero <= reg_wdata & INPUT_MASK;
    end
  end

  // register read; unmapped offsets read zero
  always @*
  begin
    next_rdata = 8'h00;
    case (reg_addr)
      `SRCIC_OFS_SYNC_REF_CLK:
        next_rdata = sync_reference_clock_control;
      `SRCIC_OFS_INPUT_MODE:
        next_rdata = input_mode_dll_autozero;
      default:
        next_rdata = 8'h00;
    endcase
  end

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end

  // edge history and power-down, registered so every output is a flop
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sw_sync_prev     <= 1'b0;
      buf_pin_prev     <= 1'b0;
      global_powerdown <= 1'b0;
    end
    else
    begin
      sw_sync_prev <= sw_sync_bit;
      buf_pin_prev <= buf_pin_level;
      global_powerdown <= pin_high & ~pin_role_sync;
    end
  end

  // sync command source; pin and register never drive it together
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      sync_command <= 1'b0;
    else if (sw_sync_en)
      // any toggle gives one pulse; only when enabled
      sync_command <= sw_sync_edge;
    else
      sync_command <= pin_high & pin_role_sync;
  end

  // reference and clock-input steering; buffer pin holds level when pin-controlled
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reference_select          <= `SRCIC_REF_INTERNAL;
      single_ended_clock_select <= 1'b0;
    end
    else
    begin
      if (ref_src_control)
        reference_select <= ref_field;
      else
        reference_select <= ref_from_pin;
      single_ended_clock_select <= ref_src_control &
                                   sync_reference_clock_control[`SRCIC_BIT_SE_CLOCK_SEL];
    end
  end

  // analog input, delay loop and auto-zero levels from the second register
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      chan_a_single_ended  <= 1'b0;
      chan_b_single_ended  <= 1'b0;
      delay_loop_powerdown <= 1'b0;
      autozero_enable      <= 1'b0;
    end
    else
    begin
      chan_a_single_ended  <= input_mode_dll_autozero[`SRCIC_BIT_CHAN_A_SE];
      chan_b_single_ended  <= input_mode_dll_autozero[`SRCIC_BIT_CHAN_B_SE];
      delay_loop_powerdown <= input_mode_dll_autozero[`SRCIC_BIT_DELAY_LOOP_PD];
      autozero_enable      <= input_mode_dll_autozero[`SRCIC_BIT_AUTOZERO];
    end
  end

endmodule

`default_nettype wire

// *** rtl/srcic_defines.vh ***
// Purpose: constants for the sync/reference/clock-input configuration bank
// Assumes: 8-bit registers on a byte-wide write/read port
// Notes:   offsets, field positions, reset values and encodings
`ifndef SRCIC_DEFINES_VH
`define SRCIC_DEFINES_VH

`define SRCIC_ADDR_W            8
`define SRCIC_OFS_SYNC_REF_CLK  8'h0E
`define SRCIC_OFS_INPUT_MODE    8'h11

// first register fields
`define SRCIC_BIT_PIN_ROLE      7
`define SRCIC_BIT_SW_SYNC       6
`define SRCIC_BIT_SW_SYNC_EN    5
`define SRCIC_BIT_REF_SRC_CTRL  3
`define SRCIC_BIT_REF_SEL_HI    2
`define SRCIC_BIT_REF_SEL_LO    1
`define SRCIC_BIT_SE_CLOCK_SEL  0
`define SRCIC_MASK_SYNC_REF_CLK 8'hEF

// second register fields
`define SRCIC_BIT_CHAN_A_SE     5
`define SRCIC_BIT_CHAN_B_SE     4
`define SRCIC_BIT_DELAY_LOOP_PD 2
`define SRCIC_BIT_AUTOZERO      0
`define SRCIC_MASK_INPUT_MODE   8'h35
`define SRCIC_MASK_INPUT_FAST   8'h31

// reset values
`define SRCIC_RST_SYNC_REF_CLK  8'h00
`define SRCIC_RST_INPUT_SLOW    8'h01
`define SRCIC_RST_INPUT_FAST    8'h00

// reference option encodings
`define SRCIC_REF_INTERNAL      2'h0
`define SRCIC_REF_EXT_BUFFERED  2'h1
`define SRCIC_REF_EXTERNAL      2'h2
`define SRCIC_REF_UNUSED        2'h3

`endif

// *** rtl/srcic_pin_sync.v ***
// Purpose: three-stage synchroniser for an asynchronous pin
// Assumes: single clock, active-low asynchronous reset
// Notes:   output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module srcic_pin_sync
(
  // clock and reset
  input  wire core_clk,
  input  wire nrst,
  // pin and result
  input  wire pin_in,
  output reg  pin_level
);

  reg stage1;
  reg stage2;
  reg stage3;

  // shift chain; stage1 feeds only stage2
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1    <= 1'b0;
      stage2    <= 1'b0;
      stage3    <= 1'b0;
      pin_level <= 1'b0;
    end
    else
    begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3)
        pin_level <= stage3;
    end
  end

endmodule

`default_nettype wire

// *** testbench/srcic_host.sv ***
// Purpose: host driving the register port
// Assumes: one strobe cycle per byte
// Notes:   raw writes skip reserved masking
`timescale 1ns/1ps
`default_nettype none
module srcic_host (
  // clock and read data
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rdata,
  // register port drive
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  // one write, held over its sampling edge
  task automatic wr(input logic [7:0] a, d, input bit raw = 0);
    @(posedge core_clk) #2;
    reg_addr = a;
    reg_wdata = raw ? d : d & (a == 8'h0E ? 8'hEF : 8'h35);
    reg_wr = 1'b1;
    @(posedge core_clk) #2;
    reg_wr = 1'b0;
  endtask
  // one read, data taken after the edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk) #2;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk) #2;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// *** testbench/srcic_monitor.sv ***
// Purpose: port checks for the config bank
// Assumes: outputs follow a write by two edges
// Notes:   pin paths are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module srcic_monitor #(parameter FAST_VARIANT = 0) (
  // clock, reset, register port
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // steering outputs
  input wire logic       sync_command,
  input wire logic       global_powerdown,
  input wire logic [1:0] reference_select,
  input wire logic       single_ended_clock_select,
  input wire logic       chan_a_single_ended,
  input wire logic       chan_b_single_ended,
  input wire logic       delay_loop_powerdown,
  input wire logic       autozero_enable
);
  // write strobes per register
  wire logic w0e = reg_wr && reg_addr == 8'h0E;
  wire logic w11 = reg_wr && reg_addr == 8'h11;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_ref_field: assert property (w0e && reg_wdata[3] |-> ##2
    reference_select == $past(reg_wdata[2:1], 2)) else $error("ref field wrong");
  a_se_clock: assert property (w0e |-> ##2 single_ended_clock_select ==
    ($past(reg_wdata[3], 2) & $past(reg_wdata[0], 2))) else $error("se clock wrong");
  a_chan_a: assert property (w11 |-> ##2
    chan_a_single_ended == $past(reg_wdata[5], 2)) else $error("chan a wrong");
  a_chan_b: assert property (w11 |-> ##2
    chan_b_single_ended == $past(reg_wdata[4], 2)) else $error("chan b wrong");
  a_delay_loop: assert property (w11 |-> ##2 delay_loop_powerdown ==
    ((FAST_VARIANT != 0) & $past(reg_wdata[2], 2))) else $error("delay loop wrong");
  a_autozero_bit: assert property (w11 |-> ##2
    autozero_enable == $past(reg_wdata[0], 2)) else $error("autozero wrong");
  a_rsvd_read: assert property (reg_rd && reg_addr == 8'h0E |=>
    !reg_rdata[4]) else $error("reserved bit read high");
  a_unmapped_read: assert property (reg_rd && reg_addr != 8'h0E && reg_addr != 8'h11
    |=> reg_rdata == 8'h00) else $error("unmapped read nonzero");
  // main scenarios reached
  c_sync: cover property (w0e ##2 sync_command);
  c_pdn: cover property ($rose(global_powerdown));
  c_in: cover property (w11 ##2 chan_a_single_ended);
endmodule
bind srcic_config_regs srcic_monitor #(.FAST_VARIANT(FAST_VARIANT)) mon (.*);
`default_nettype wire

// *** testbench/tb_sync_ref_clock_input_config.sv ***
// Purpose: bench for the config bank
// Assumes: both variants on one bus, outputs packed as outs and fast_outs
// Notes:   pin paths settle within six edges
`timescale 1ns/1ps
`default_nettype none
module tb_sync_ref_clock_input_config;
  logic core_clk = 0, nrst = 0, shared_sync_powerdown_pin = 0, reference_buffer_pin = 0;
  wire logic reg_wr, reg_rd, global_powerdown, sync_command, single_ended_clock_select;
  wire logic chan_a_single_ended, chan_b_single_ended, delay_loop_powerdown, autozero_enable;
  wire logic [7:0] reg_addr, reg_wdata, reg_rdata;
  wire logic [1:0] reference_select;
  wire logic [8:0] fast_outs;
  wire logic [7:0] fast_rdata;
  int miscompares = 0, samples_checked = 0;
  logic [7:0] d;
  // all steering outputs in one word
  wire logic [8:0] outs = {global_powerdown, sync_command, reference_select,
    single_ended_clock_select, chan_a_single_ended, chan_b_single_ended,
    delay_loop_powerdown, autozero_enable};
  srcic_host host (.*);
  srcic_config_regs dut (.*);
  // fastest variant on the same bus: delay loop bit kept, auto-zero off at reset
  srcic_config_regs #(.FAST_VARIANT(1)) dut_fast (
    .core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(fast_rdata),
    .shared_sync_powerdown_pin(shared_sync_powerdown_pin),
    .reference_buffer_pin(reference_buffer_pin),
    .global_powerdown(fast_outs[8]), .sync_command(fast_outs[7]),
    .reference_select(fast_outs[6:5]), .single_ended_clock_select(fast_outs[4]),
    .chan_a_single_ended(fast_outs[3]), .chan_b_single_ended(fast_outs[2]),
    .delay_loop_powerdown(fast_outs[1]), .autozero_enable(fast_outs[0]));
  initial forever #25 core_clk = ~core_clk;
  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic chk(input string n, input logic [8:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  // counts sync pulses after one write
  task automatic pulses(input logic [7:0] w, input logic [8:0] e);
    logic [8:0] k;
    k = 0;
    host.wr(8'h0E, w);
    repeat (5)
    begin
      k = k + sync_command;
      cyc(1);
    end
    chk("pulses", k, e);
  endtask
  task automatic t_ref;
    for (int i = 0; i < 4; i++)
    begin
      host.wr(8'h0E, 8'h09 | (i[7:0] << 1));
      cyc(2);
      chk("ref", outs, 9'h011 | (i[8:0] << 5));
    end
    reference_buffer_pin = 1'b1;
    host.wr(8'h0E, 8'h01);
    cyc(6);
    chk("refpin", outs, 9'h021);
    reference_buffer_pin = 1'b0;
  endtask
  task automatic t_pin;
    host.wr(8'h0E, 8'h00);
    shared_sync_powerdown_pin = 1'b1;
    cyc(6);
    chk("pdn", outs, 9'h101);
    host.wr(8'h0E, 8'h80);
    cyc(2);
    chk("pinsync", outs, 9'h081);
    host.wr(8'h0E, 8'hA0);
    cyc(2);
    chk("regsync", outs, 9'h001);
    shared_sync_powerdown_pin = 1'b0;
    cyc(6);
  endtask
  task automatic t_in;
    host.wr(8'h11, 8'hFF, 1);
    cyc(2);
    chk("in", outs, 9'h00D);
    chk("infast", fast_outs, 9'h00F);
    host.rd(8'h11, d);
    chk("rd11", d, 8'h31);
    chk("rd11fast", fast_rdata, 8'h35);
    host.wr(8'h0E, 8'h10, 1);
    host.rd(8'h0E, d);
    chk("rd0e", d, 8'h00);
    host.rd(8'h0F, d);
    chk("unmapped", d, 8'h00);
    host.wr(8'h11, 8'h20);
    cyc(2);
    chk("sea", outs, 9'h008);
    host.wr(8'h11, 8'h10);
    cyc(2);
    chk("seb", outs, 9'h004);
  endtask
  task automatic give_verdict;
    if (miscompares == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // reset, then scenarios in order
  initial
  begin
    repeat (10) @(posedge core_clk);
    #2 nrst = 1'b1;
    cyc(1);
    chk("rst", outs, 9'h001);
    chk("rstfast", fast_outs, 9'h000);
    host.rd(8'h11, d);
    chk("rst11", d, 8'h01);
    chk("rst11fast", fast_rdata, 8'h00);
    t_ref;
    t_pin;
    pulses(8'hE0, 9'h001);
    pulses(8'hA0, 9'h001);
    pulses(8'h40, 9'h000);
    pulses(8'h60, 9'h000);
    t_in;
    give_verdict;
  end
endmodule
`default_nettype wire
